/* File: hw/ffm_pkg.sv */
// Shared constants and types for the FIFO flag, mailbox and bus-match block.
// Assumes every user imports the whole package; no clocks live here.
package ffm_pkg;

    // Widths and depths
    localparam int unsigned FFM_WORD_W        = 36;
    localparam int unsigned FFM_DEPTH_DEFAULT = 4096;
    localparam int unsigned FFM_OFFSET_PRESET = 8;
    localparam int unsigned FFM_WORD_CHUNK    = 18;
    localparam int unsigned FFM_BYTE_CHUNK    = 9;

    // Port B edges seen in reset before the empty flag drops
    localparam logic [1:0] FFM_EF_EDGES_FT  = 2'h1;
    localparam logic [1:0] FFM_EF_EDGES_STD = 2'h2;

    // Lane masks per Port B bus size
    localparam logic [35:0] FFM_MASK_LONG = 36'hf_ffff_ffff;
    localparam logic [35:0] FFM_MASK_WORD = 36'h0_0003_ffff;
    localparam logic [35:0] FFM_MASK_BYTE = 36'h0_0000_01ff;

    // Port bundle layout: {chip_select_n, direction, en, mail_sel, data}
    localparam int unsigned FFM_PORT_W   = 40;
    localparam int unsigned FFM_BIT_CS_N = 39;
    localparam int unsigned FFM_BIT_DIR  = 38;
    localparam int unsigned FFM_BIT_EN   = 37;
    localparam int unsigned FFM_BIT_MAIL = 36;

    // Miscellaneous pin bundle layout
    localparam int unsigned FFM_MISC_W      = 8;
    localparam int unsigned FFM_BIT_MRST_N  = 0;
    localparam int unsigned FFM_BIT_PRST_N  = 1;
    localparam int unsigned FFM_BIT_ENDIAN  = 2;
    localparam int unsigned FFM_BIT_BM      = 3;
    localparam int unsigned FFM_BIT_SIZE    = 4;
    localparam int unsigned FFM_BIT_SER_D   = 5;
    localparam int unsigned FFM_BIT_SER_EN  = 6;
    localparam int unsigned FFM_BIT_PRESET  = 7;

    typedef enum logic [1:0] {
        FFM_SIZE_LONG = 2'b00,
        FFM_SIZE_WORD = 2'b01,
        FFM_SIZE_BYTE = 2'b10
    } ffm_size_t;

    typedef enum logic [1:0] {
        FFM_ST_RESET = 2'b00,
        FFM_ST_PROG  = 2'b01,
        FFM_ST_RUN   = 2'b10
    } ffm_state_t;

    // Usable lanes for a given Port B size
    function automatic logic [35:0] ffm_lane_mask(input ffm_size_t size);
        logic [35:0] m;
        m = FFM_MASK_LONG;
        if (size == FFM_SIZE_WORD) begin
            m = FFM_MASK_WORD;
        end else if (size == FFM_SIZE_BYTE) begin
            m = FFM_MASK_BYTE;
        end
        return m;
    endfunction : ffm_lane_mask

endpackage : ffm_pkg

/* File: hw/ffm_mail_if.sv */
// Carrier between the top block and one mailbox register.
// Assumes all signals live on the single system clock.
`timescale 1ns/10ps
interface ffm_mail_if;
    logic        wr;
    logic        rd;
    logic        clr;
    logic [35:0] din;
    logic [35:0] mask;
    logic [35:0] dout;
    logic        full_n;

    modport owner (input wr, rd, clr, din, mask, output dout, full_n);
    modport user  (output wr, rd, clr, din, mask, input dout, full_n);
endinterface : ffm_mail_if

/* File: hw/ffm_sync.sv */
// Two-stage synchroniser with a rising-edge pulse on the settled level.
// Assumes d_in is asynchronous to clk_in; a third stage feeds the edge detect.
`timescale 1ns/10ps
module ffm_sync #(
    parameter int unsigned W = 1
) (
    input  logic         clk_in,
    input  logic         rst_in,
    input  logic [W-1:0] d_in,
    output logic [W-1:0] q_out,
    output logic [W-1:0] rise_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } ffm_sync_st_t;

    ffm_sync_st_t st;
    ffm_sync_st_t next_st;

    // Stage one is read only by stage two
    always_comb begin
        next_st    = st;
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    // Reset loads the live pin into every stage so no false edge follows
    // release; stages may settle late, so hold reset for three edges
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '{s1: d_in, s2: d_in, s3: d_in};
        end else begin
            st <= next_st;
        end
    end

    assign q_out    = st.s2;
    assign rise_out = st.s2 & ~st.s3;
endmodule : ffm_sync

/* File: hw/ffm_mailbox.sv */
// One bypass mailbox register with its active-low full flag.
// Assumes wr and rd are one-cycle pulses already qualified by port edges.
`timescale 1ns/10ps
module ffm_mailbox (
    input  logic       clk_in,
    input  logic       rst_in,
    ffm_mail_if.owner  mb
);
    typedef struct packed {
        logic [35:0] data;
        logic        full_n;
    } ffm_mbox_st_t;

    ffm_mbox_st_t st;
    ffm_mbox_st_t next_st;

    // Write beats a same-cycle read only while empty; a write to a full mailbox is dropped
    always_comb begin
        next_st = st;
        if (mb.clr) begin
            next_st.full_n = 1'b1;
        end else if (mb.wr && st.full_n) begin
            next_st.data   = mb.din & mb.mask;
            next_st.full_n = 1'b0;
        end else if (mb.rd) begin
            next_st.full_n = 1'b1;
        end
    end

    // Data survives reads; only a write or the system reset replaces it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '{data: '0, full_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign mb.dout   = st.data;
    assign mb.full_n = st.full_n;
endmodule : ffm_mailbox

/* File: hw/ffm_flag_mailbox.sv */
// Write-to-read FIFO with almost-full flag, two mailboxes and Port B sizing.
// Assumes port clocks and all pins are asynchronous to mclk_in (200 MHz);
// each port clock must stay well below a quarter of mclk_in.
`timescale 1ns/10ps
module ffm_flag_mailbox
    import ffm_pkg::*;
#(
    parameter int unsigned DEPTH = FFM_DEPTH_DEFAULT
) (
    input  logic        mclk_in,
    input  logic        reset_in,
    input  logic        port_a_clock_in,
    input  logic        port_b_clock_in,
    input  logic        master_reset_n_in,
    input  logic        partial_reset_n_in,
    input  logic        port_a_chip_select_n_in,
    input  logic        port_a_direction_in,
    input  logic        port_a_en_in,
    input  logic        port_a_mail_sel_in,
    input  logic [35:0] port_a_data_in,
    input  logic        port_b_chip_select_n_in,
    input  logic        port_b_direction_in,
    input  logic        port_b_en_in,
    input  logic        port_b_mail_sel_in,
    input  logic [35:0] port_b_data_in,
    input  logic        bus_match_sel_in,
    input  logic        bus_size_sel_in,
    input  logic        endian_fallthrough_sel_in,
    input  logic        serial_offset_in,
    input  logic        serial_offset_en_in,
    input  logic        offset_preset_sel_in,
    output logic [35:0] port_a_data_out,
    output logic        port_a_data_oe_out,
    output logic [35:0] port_b_data_out,
    output logic        port_b_data_oe_out,
    output logic        almost_full_n_out,
    output logic        full_inrdy_flag_out,
    output logic        empty_outrdy_flag_out,
    output logic        a_to_b_mail_full_n_out,
    output logic        b_to_a_mail_full_n_out
);
    localparam int unsigned ADDR_W = $clog2(DEPTH);
    localparam int unsigned PTR_W  = ADDR_W + 1;
    localparam int unsigned SER_W  = 2 * ADDR_W;
    localparam int unsigned CNT_W  = $clog2(SER_W + 1);
    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    localparam logic [ADDR_W-1:0] PRESET_P = ADDR_W'(FFM_OFFSET_PRESET);
    localparam logic [CNT_W-1:0] SER_LAST = CNT_W'(SER_W - 1);

    typedef struct packed {
        ffm_state_t        state;
        logic              partial;
        logic [PTR_W-1:0]  wptr;
        logic [PTR_W-1:0]  rptr;
        logic [PTR_W-1:0]  rptr_a1;
        logic [PTR_W-1:0]  rptr_a2;
        logic [PTR_W-1:0]  wptr_b1;
        logic [PTR_W-1:0]  wptr_b2;
        logic [SER_W-1:0]  offsets;
        logic [CNT_W-1:0]  ser_cnt;
        ffm_size_t         size;
        logic              big_end;
        logic [35:0]       aux;
        logic [1:0]        piece;
        logic [1:0]        left;
        logic [35:0]       out_reg;
        logic [1:0]        ef_cnt;
        logic              af_n;
        logic              full_ir;
        logic              empty_or;
        logic [35:0]       a_dout;
        logic              a_oe;
        logic [35:0]       b_dout;
        logic              b_oe;
        logic              mf_ab;
        logic              mf_ba;
    } ffm_top_st_t;

    ffm_top_st_t st;
    ffm_top_st_t next_st;

    logic [35:0]           mem [DEPTH];
    logic [1:0]            clk_rise;
    logic [FFM_PORT_W-1:0] a_pins;
    logic [FFM_PORT_W-1:0] b_pins;
    logic [FFM_MISC_W-1:0] misc;
    logic [FFM_MISC_W-1:0] misc_rise;
    logic                  a_edge;
    logic                  b_edge;
    logic                  a_sel;
    logic                  b_sel;
    logic                  fifo_wr;
    logic                  in_reset;
    logic [35:0]           mem_word;

    ffm_mail_if ab_if ();
    ffm_mail_if ba_if ();

    // Port clocks sampled as data; their rises become enables
    ffm_sync #(.W(2)) u_clk_sync (
        .clk_in   (mclk_in),
        .rst_in   (reset_in),
        .d_in     ({port_b_clock_in, port_a_clock_in}),
        .q_out    (),
        .rise_out (clk_rise)
    );

    // Port pins share the clock path depth so they line up with edges
    ffm_sync #(.W(FFM_PORT_W)) u_a_sync (
        .clk_in   (mclk_in),
        .rst_in   (reset_in),
        .d_in     ({port_a_chip_select_n_in, port_a_direction_in,
                    port_a_en_in, port_a_mail_sel_in, port_a_data_in}),
        .q_out    (a_pins),
        .rise_out ()
    );

    ffm_sync #(.W(FFM_PORT_W)) u_b_sync (
        .clk_in   (mclk_in),
        .rst_in   (reset_in),
        .d_in     ({port_b_chip_select_n_in, port_b_direction_in,
                    port_b_en_in, port_b_mail_sel_in, port_b_data_in}),
        .q_out    (b_pins),
        .rise_out ()
    );

    ffm_sync #(.W(FFM_MISC_W)) u_misc_sync (
        .clk_in   (mclk_in),
        .rst_in   (reset_in),
        .d_in     ({offset_preset_sel_in, serial_offset_en_in,
                    serial_offset_in, bus_size_sel_in, bus_match_sel_in,
                    endian_fallthrough_sel_in, partial_reset_n_in,
                    master_reset_n_in}),
        .q_out    (misc),
        .rise_out (misc_rise)
    );

    // Port decode: selected means chip select low and enable high
    assign a_edge   = clk_rise[0];
    assign b_edge   = clk_rise[1];
    assign a_sel    = a_edge & ~a_pins[FFM_BIT_CS_N] & a_pins[FFM_BIT_EN];
    assign b_sel    = b_edge & ~b_pins[FFM_BIT_CS_N] & b_pins[FFM_BIT_EN];
    assign in_reset = ~misc[FFM_BIT_MRST_N] | ~misc[FFM_BIT_PRST_N];
    assign mem_word = mem[st.rptr[ADDR_W-1:0]];

    // Only whole long words enter memory; ignored until input-ready is high
    assign fifo_wr = a_sel & a_pins[FFM_BIT_DIR] & ~a_pins[FFM_BIT_MAIL]
                   & st.full_ir & (st.state == FFM_ST_RUN);

    // Mailbox hookups; lane masks follow the latched Port B size
    assign ab_if.wr   = a_sel & a_pins[FFM_BIT_DIR] & a_pins[FFM_BIT_MAIL]
                      & (st.state == FFM_ST_RUN);
    assign ab_if.rd   = b_sel & b_pins[FFM_BIT_DIR] & b_pins[FFM_BIT_MAIL];
    assign ab_if.clr  = in_reset;
    assign ab_if.din  = a_pins[35:0];
    assign ab_if.mask = ffm_lane_mask(st.size);
    assign ba_if.wr   = b_sel & ~b_pins[FFM_BIT_DIR] & b_pins[FFM_BIT_MAIL]
                      & (st.state == FFM_ST_RUN);
    assign ba_if.rd   = a_sel & ~a_pins[FFM_BIT_DIR] & a_pins[FFM_BIT_MAIL];
    assign ba_if.clr  = in_reset;
    assign ba_if.din  = b_pins[35:0];
    assign ba_if.mask = ffm_lane_mask(st.size);

    ffm_mailbox u_mail_ab (
        .clk_in (mclk_in),
        .rst_in (reset_in),
        .mb     (ab_if.owner)
    );

    ffm_mailbox u_mail_ba (
        .clk_in (mclk_in),
        .rst_in (reset_in),
        .mb     (ba_if.owner)
    );

    // Piece k of a long word in the chosen endian order, low lanes only
    function automatic logic [35:0] piece_of(input logic [35:0] word,
                                             input ffm_size_t   size,
                                             input logic        big,
                                             input logic [1:0]  k);
        logic [1:0]  p;
        logic [35:0] r;
        p = big ? ~k : k;
        r = word;
        if (size == FFM_SIZE_WORD) begin
            p = big ? {1'b0, ~k[0]} : k;
            r = (word >> (p[0] ? FFM_WORD_CHUNK : 0)) & FFM_MASK_WORD;
        end else if (size == FFM_SIZE_BYTE) begin
            r = (word >> (6'(p) * 6'(FFM_BYTE_CHUNK))) & FFM_MASK_BYTE;
        end
        return r;
    endfunction : piece_of

    // Pieces left after the first one for each size
    function automatic logic [1:0] extra_pieces(input ffm_size_t size);
        logic [1:0] n;
        n = 2'h0;
        if (size == FFM_SIZE_WORD) begin
            n = 2'h1;
        end else if (size == FFM_SIZE_BYTE) begin
            n = 2'h3;
        end
        return n;
    endfunction : extra_pieces

    // Main next-state logic
    always_comb begin
        logic [PTR_W-1:0] fill_a;
        logic [PTR_W-1:0] af_level;
        logic             b_fifo_rd;
        logic [1:0]       ef_target;
        fill_a    = '0;
        af_level  = '0;
        b_fifo_rd = 1'b0;
        ef_target = FFM_EF_EDGES_STD;
        next_st   = st;

        // Endian caught on the release edge of master reset
        if (misc_rise[FFM_BIT_MRST_N]) begin
            next_st.big_end = misc[FFM_BIT_ENDIAN];
        end

        // Reset and offset loading sequence
        unique case (st.state)
            FFM_ST_RESET: begin
                if (!in_reset) begin
                    next_st.state = st.partial ? FFM_ST_RUN : FFM_ST_PROG;
                end
            end
            FFM_ST_PROG: begin
                if (a_edge && misc[FFM_BIT_PRESET]) begin
                    next_st.offsets = {PRESET_P, PRESET_P};
                    next_st.state   = FFM_ST_RUN;
                end else if (a_edge && misc[FFM_BIT_SER_EN]) begin
                    // Y bits land first and end up in the upper half
                    next_st.offsets = {st.offsets[SER_W-2:0],
                                       misc[FFM_BIT_SER_D]};
                    next_st.ser_cnt = st.ser_cnt + 1'b1;
                    if (st.ser_cnt == SER_LAST) begin
                        next_st.state = FFM_ST_RUN;
                    end
                end
            end
            FFM_ST_RUN: begin
            end
            default: begin
                next_st.state = FFM_ST_RESET;
            end
        endcase

        // Size is latched as the part enters run, from programming or straight from a partial reset
        if (next_st.state == FFM_ST_RUN && st.state != FFM_ST_RUN) begin
            if (!misc[FFM_BIT_BM]) begin
                next_st.size = FFM_SIZE_LONG;
            end else if (!misc[FFM_BIT_SIZE]) begin
                next_st.size = FFM_SIZE_WORD;
            end else begin
                next_st.size = FFM_SIZE_BYTE;
            end
        end

        // Write side pointer and its copies in the Port B edge domain
        if (fifo_wr) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (b_edge) begin
            next_st.wptr_b1 = st.wptr;
            next_st.wptr_b2 = st.wptr_b1;
        end

        // Port B FIFO read: drain held pieces before fetching a new word
        b_fifo_rd = b_sel & b_pins[FFM_BIT_DIR] & ~b_pins[FFM_BIT_MAIL]
                  & st.empty_or & (st.state == FFM_ST_RUN);
        if (b_fifo_rd) begin
            if (st.left != 2'h0) begin
                next_st.piece   = st.piece + 1'b1;
                next_st.left    = st.left - 1'b1;
                next_st.out_reg = piece_of(st.aux, st.size, st.big_end,
                                           st.piece + 1'b1);
            end else if (st.wptr_b2 != st.rptr) begin
                // Fetched word counts as gone from memory at once
                next_st.rptr    = st.rptr + 1'b1;
                next_st.aux     = mem_word;
                next_st.piece   = 2'h0;
                next_st.left    = extra_pieces(st.size);
                next_st.out_reg = piece_of(mem_word, st.size, st.big_end,
                                           2'h0);
            end
        end

        // Read pointer reaches Port A logic through two Port A edges
        if (a_edge) begin
            next_st.rptr_a1 = st.rptr;
            next_st.rptr_a2 = st.rptr_a1;
        end

        // Clears of data; partial reset keeps offsets and endian, and size is latched again on leaving reset
        if (in_reset) begin
            next_st.state   = FFM_ST_RESET;
            next_st.partial = misc[FFM_BIT_MRST_N];
            next_st.wptr    = '0;
            next_st.rptr    = '0;
            next_st.rptr_a1 = '0;
            next_st.rptr_a2 = '0;
            next_st.wptr_b1 = '0;
            next_st.wptr_b2 = '0;
            next_st.left    = 2'h0;
            next_st.piece   = 2'h0;
            next_st.ser_cnt = '0;
        end

        // Almost-full compares against the delayed read pointer
        fill_a        = next_st.wptr - next_st.rptr_a2;
        af_level      = DEPTH_P - {1'b0, next_st.offsets[SER_W-1:ADDR_W]};
        next_st.af_n  = (fill_a < af_level);
        next_st.full_ir = (next_st.state == FFM_ST_RUN)
                        && (fill_a < DEPTH_P);

        // Empty drops in reset after one or two Port B edges
        if (misc[FFM_BIT_ENDIAN]) begin
            ef_target = FFM_EF_EDGES_FT;
        end
        if (in_reset) begin
            if (b_edge && st.ef_cnt != FFM_EF_EDGES_STD) begin
                next_st.ef_cnt = st.ef_cnt + 1'b1;
            end
            if (next_st.ef_cnt >= ef_target) begin
                next_st.empty_or = 1'b0;
            end
        end else begin
            next_st.ef_cnt   = 2'h0;
            next_st.empty_or = (next_st.state == FFM_ST_RUN)
                             && ((next_st.wptr_b2 != next_st.rptr)
                                 || (next_st.left != 2'h0));
        end

        // Output drive: mailbox when mail select is high, else FIFO on Port B and zero on Port A
        next_st.a_oe   = ~a_pins[FFM_BIT_CS_N] & ~a_pins[FFM_BIT_DIR];
        next_st.a_dout = a_pins[FFM_BIT_MAIL]
                       ? (ba_if.dout & ffm_lane_mask(st.size))
                       : 36'h0_0000_0000;
        next_st.b_oe   = ~b_pins[FFM_BIT_CS_N] & b_pins[FFM_BIT_DIR];
        next_st.b_dout = b_pins[FFM_BIT_MAIL]
                       ? (ab_if.dout & ffm_lane_mask(st.size))
                       : next_st.out_reg;
        next_st.mf_ab  = ab_if.full_n;
        next_st.mf_ba  = ba_if.full_n;
    end

    // FIFO memory, written only by qualified Port A edges
    always_ff @(posedge mclk_in) begin
        if (fifo_wr) begin
            mem[st.wptr[ADDR_W-1:0]] <= a_pins[35:0];
        end
    end

    // State register; the system reset forces known constants
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st          <= '0;
            st.state    <= FFM_ST_RESET;
            st.size     <= FFM_SIZE_LONG;
            st.offsets  <= {PRESET_P, PRESET_P};
            st.af_n     <= 1'b1;
            st.mf_ab    <= 1'b1;
            st.mf_ba    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Every output taken straight from a register
    assign port_a_data_out        = st.a_dout;
    assign port_a_data_oe_out     = st.a_oe;
    assign port_b_data_out        = st.b_dout;
    assign port_b_data_oe_out     = st.b_oe;
    assign almost_full_n_out      = st.af_n;
    assign full_inrdy_flag_out    = st.full_ir;
    assign empty_outrdy_flag_out  = st.empty_or;
    assign a_to_b_mail_full_n_out = st.mf_ab;
    assign b_to_a_mail_full_n_out = st.mf_ba;
endmodule : ffm_flag_mailbox

/* File: verification/ffm_props.sv */
// Checker for mailbox flags, lane widths and almost-full timing.
// Sees only top ports; pins lead flags by 3 clocks, mailbox flags by 4.
`timescale 1ns/10ps
module ffm_props (
    input wire logic mclk_in, reset_in, master_reset_n_in, port_a_clock_in,
    input wire logic port_a_chip_select_n_in, port_a_direction_in,
    input wire logic port_b_chip_select_n_in, port_b_direction_in,
    input wire logic port_a_mail_sel_in, port_b_mail_sel_in,
    input wire logic bus_match_sel_in, bus_size_sel_in, port_b_data_oe_out,
    input wire logic port_a_data_oe_out,
    input wire logic [35:0] port_a_data_out, port_b_data_out,
    input wire logic almost_full_n_out, full_inrdy_flag_out,
    input wire logic a_to_b_mail_full_n_out, b_to_a_mail_full_n_out
);
    default clocking @(posedge mclk_in); endclocking
    // Device reset forces flags itself, so it masks the checks
    default disable iff (reset_in || !master_reset_n_in);
    wire a_sel = !port_a_chip_select_n_in && port_a_mail_sel_in;
    wire b_sel = !port_b_chip_select_n_in && port_b_mail_sel_in;
    wire byte_sz = bus_match_sel_in && bus_size_sel_in;
    property p_mb1_set;
        $fell(a_to_b_mail_full_n_out) |-> $past(a_sel && port_a_direction_in, 4);
    endproperty
    a_mb1_set: assert property (p_mb1_set) else $error("mb1 set cause");
    property p_mb1_clr;
        $rose(a_to_b_mail_full_n_out) |-> $past(b_sel && port_b_direction_in, 4);
    endproperty
    a_mb1_clr: assert property (p_mb1_clr) else $error("mb1 clear cause");
    property p_mb2_set;
        $fell(b_to_a_mail_full_n_out) |-> $past(b_sel && !port_b_direction_in, 4);
    endproperty
    a_mb2_set: assert property (p_mb2_set) else $error("mb2 set cause");
    property p_mb2_clr;
        $rose(b_to_a_mail_full_n_out) |-> $past(a_sel && !port_a_direction_in, 4);
    endproperty
    a_mb2_clr: assert property (p_mb2_clr) else $error("mb2 clear cause");
    property p_lane_b;
        byte_sz |-> port_b_data_out[35:9] == 27'h000_0000;
    endproperty
    a_lane_b: assert property (p_lane_b) else $error("port b lanes");
    property p_lane_a;
        byte_sz |-> port_a_data_out[35:9] == 27'h000_0000;
    endproperty
    a_lane_a: assert property (p_lane_a) else $error("port a lanes");
    property p_af_edge;
        $changed(almost_full_n_out) |->
            $past(port_a_clock_in, 3) && !$past(port_a_clock_in, 4);
    endproperty
    a_af_edge: assert property (p_af_edge) else $error("af off edge");
    property p_oe_b;
        port_b_data_oe_out |->
            $past(!port_b_chip_select_n_in && port_b_direction_in, 3);
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("port b oe");
    property p_oe_a;
        port_a_data_oe_out |->
            $past(!port_a_chip_select_n_in && !port_a_direction_in, 3);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("port a oe");
    property p_rst;
        disable iff (reset_in) $fell(master_reset_n_in) |->
            ##4 !full_inrdy_flag_out && a_to_b_mail_full_n_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset flags");
    c_mb1: cover property ($fell(a_to_b_mail_full_n_out));
    c_mb2: cover property ($fell(b_to_a_mail_full_n_out));
    c_af: cover property ($rose(almost_full_n_out));
endmodule : ffm_props
bind ffm_flag_mailbox ffm_props u_ffm_props (.*);

/* File: verification/ffm_host_clk.sv */
// Host-side port clocks, free running as on the real buses.
// Assumes periods well above 4 system clocks.
`timescale 1ns/10ps
module ffm_host_clk (
    output logic port_a_clock_out,
    output logic port_b_clock_out
);
    // Unrelated periods keep the two edges drifting apart
    initial begin
        port_a_clock_out = 1'b0;
        forever #25 port_a_clock_out = ~port_a_clock_out;
    end
    initial begin
        port_b_clock_out = 1'b0;
        forever #32.3 port_b_clock_out = ~port_b_clock_out;
    end
endmodule : ffm_host_clk

/* File: verification/tb_top.sv */
// Bench for mailboxes, byte sizing and almost-full with depth 16.
// Assumes preset offsets of 8 and byte size, big endian, held static.
`timescale 1ns/10ps
module tb_top;
    import ffm_pkg::*;
    logic mclk_in, reset_in, ca, cb, ir, ef, af_n, m1_n, m2_n;
    logic [39:0] pa, pb;
    logic [7:0]  misc;
    logic [35:0] ad, bd, w;
    logic [35:0] q [8];
    int          err_count, cmp_count;
    ffm_host_clk u_ffm_host_clk (.port_a_clock_out(ca), .port_b_clock_out(cb));
    ffm_flag_mailbox #(.DEPTH(16)) u_ffm_flag_mailbox (
        .mclk_in(mclk_in), .reset_in(reset_in),
        .port_a_clock_in(ca), .port_b_clock_in(cb),
        .master_reset_n_in(misc[0]), .partial_reset_n_in(misc[1]),
        .endian_fallthrough_sel_in(misc[2]), .bus_match_sel_in(misc[3]),
        .bus_size_sel_in(misc[4]), .serial_offset_in(misc[5]),
        .serial_offset_en_in(misc[6]), .offset_preset_sel_in(misc[7]),
        .port_a_chip_select_n_in(pa[39]), .port_a_direction_in(pa[38]),
        .port_a_en_in(pa[37]), .port_a_mail_sel_in(pa[36]),
        .port_a_data_in(pa[35:0]), .port_b_data_in(pb[35:0]),
        .port_b_chip_select_n_in(pb[39]), .port_b_direction_in(pb[38]),
        .port_b_en_in(pb[37]), .port_b_mail_sel_in(pb[36]),
        .port_a_data_out(ad), .port_a_data_oe_out(), .port_b_data_out(bd),
        .port_b_data_oe_out(), .almost_full_n_out(af_n),
        .full_inrdy_flag_out(ir), .empty_outrdy_flag_out(ef),
        .a_to_b_mail_full_n_out(m1_n), .b_to_a_mail_full_n_out(m2_n));
    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    // Pins held for a whole port cycle so the rise sees them settled
    task automatic opa(input logic [3:0] c, input logic [35:0] d);
        @(negedge ca);
        @(negedge mclk_in) pa = {c, d};
        @(negedge ca);
        @(negedge mclk_in) pa[39] = 1'b1;
    endtask : opa
    task automatic opb(input logic [3:0] c, input logic [35:0] d);
        @(negedge cb);
        @(negedge mclk_in) pb = {c, d};
        @(negedge cb);
        @(negedge mclk_in) pb[39] = 1'b1;
    endtask : opb
    task automatic wt(ref logic s);
        for (int n = 0; n < 999 && s !== 1'b1; n++) @(negedge mclk_in);
    endtask : wt
    // Big endian byte order, piece on the low lanes
    function automatic logic [35:0] piece(input logic [35:0] v, input int k);
        return {27'h000_0000, v[35-9*k -: 9]};
    endfunction : piece
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial begin
        #100000;
        err_count++;
        $display("unexpected at %0t: watchdog", $time);
        final_report();
    end
    initial begin
        reset_in = 1'b1;
        pa = 40'h80_0000_0000;
        pb = 40'h80_0000_0000;
        misc = 8'h9f; // Partial reset stays high throughout
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h4eb2));
        repeat (12) @(negedge mclk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        misc[0] = 1'b0;
        repeat (20) @(negedge mclk_in);
        misc[0] = 1'b1;
        wt(ir);
        chk(ir, 1'b1);
        w = 36'({$urandom(), $urandom()});
        opa(4'h7, w);
        chk(m1_n, 1'b0);
        opa(4'h7, ~w);
        opb(4'h7, 36'h0);
        chk(bd, w & FFM_MASK_BYTE);
        chk(m1_n, 1'b1);
        opb(4'h7, 36'h0);
        chk(bd, w & FFM_MASK_BYTE);
        opb(4'h3, ~w);
        chk(m2_n, 1'b0);
        opa(4'h3, 36'h0);
        chk(ad, ~w & FFM_MASK_BYTE);
        chk(m2_n, 1'b1);
        $display("mailbox test done");
        for (int i = 0; i < 8; i++) begin
            q[i] = 36'({$urandom(), $urandom()});
            opa(4'h6, q[i]);
            if (i == 6) chk(af_n, 1'b1);
        end
        chk(af_n, 1'b0);
        wt(ef);
        chk(ef, 1'b1);
        for (int k = 0; k < 4; k++) begin
            opb(4'h6, 36'h0);
            chk(bd, piece(q[0], k));
            if (k == 0) chk(af_n, 1'b0);
        end
        chk(af_n, 1'b1);
        $display("fifo test done");
        final_report();
    end
endmodule : tb_top
